// ==== fcr_consts.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the flash register bank
// Assumes: register index n sits at byte address 4*n on the AXI4-Lite bus
// Notes:   definitions only
`ifndef FCR_CONSTS_SVH
`define FCR_CONSTS_SVH
// ==========================================================================
// register indices (byte address is four times the index)
`define FCR_IDX_CLKDIV   6'h00
`define FCR_IDX_SEC      6'h01
`define FCR_IDX_COMMAND_WORD_SELECT   6'h02
`define FCR_IDX_RSV0     6'h03
`define FCR_IDX_CNFG     6'h04
`define FCR_IDX_ERCNFG   6'h05
`define FCR_IDX_STAT     6'h06
`define FCR_IDX_ERSTAT   6'h07
`define FCR_IDX_PROGRAM_FLASH_PROTECTION    6'h08
`define FCR_IDX_DATA_FLASH_PROTECTION   6'h09
`define FCR_IDX_CCOBHI   6'h0A
`define FCR_IDX_CCOBLO   6'h0B
`define FCR_IDX_LAST     6'h13
// ==========================================================================
// field positions
`define FCR_BIT_LOADED   7
`define FCR_BIT_LOCK     6
`define FCR_BIT_COMMAND_COMPLETE_FLAG     7
`define FCR_BIT_COMMAND_COMPLETE_IRQ_ENABLE     7
`define FCR_BIT_IGNSF    4
`define FCR_BIT_FDFD     1
`define FCR_BIT_FSFD     0
// ==========================================================================
// bus answers, reset values, timing
`define FCR_RESP_OKAY    2'h0
`define FCR_RESP_SLVERR  2'h2
`define FCR_SEC_RESET    8'h00
`define FCR_CMD_TICKS    8'h04
`endif

// ==== fcr_pkg.sv ====
// Purpose: types of the flash register bank
// Assumes: fcr_consts.svh for all numbers
// Notes:   one packed struct holds all state of the top module except the check registers gap and div_chg
`default_nettype none
package fcr_pkg;
  // command engine states, one-hot
  typedef enum logic [1:0] {
    FCR_CMD_IDLE = 2'b01,
    FCR_CMD_RUN  = 2'b10
  } fcr_cmd_t;

  // whole state of the register bank
  typedef struct packed {
    logic             awready;
    logic             wready;
    logic             arready;
    logic             bvalid;
    logic             rvalid;
    logic [1:0]       bresp;
    logic [1:0]       rresp;
    logic [7:0]       rdata;
    logic             aw_have;
    logic             w_have;
    logic [5:0]       waddr;
    logic [7:0]       wdata;
    logic             wen;
    logic             loaded;
    logic             lock;
    logic [5:0]       div;
    logic [5:0]       div_cnt;
    logic             tick;
    logic [2:0]       command_word_select;
    logic [3:0]       cnfg;
    logic [1:0]       ercnfg;
    logic [7:0]       program_flash_protection;
    logic [7:0]       data_flash_protection;
    logic [7:0][15:0] ccob;
    fcr_cmd_t         cmd_st;
    logic [7:0]       cmd_cnt;
    logic             irq;
  } fcr_state_t;
endpackage
`default_nettype wire

// ==== fcr_regs.sv ====
// Purpose: flash controller register bank with clock divider, on AXI4-Lite
// Assumes: one clock aclk, synchronous active-low reset, 8-bit registers in byte lane 0
// Notes:   a small command timer stands in for the flash command engine
`include "fcr_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module fcr_regs #(
  parameter logic [7:0] SEC_VALUE = `FCR_SEC_RESET,
  parameter logic [7:0] CMD_TICKS = `FCR_CMD_TICKS
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  // write response
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // block outputs
  output var  logic        cmd_complete_irq,
  output var  logic        tick_1mhz
);
  import fcr_pkg::*;

  fcr_state_t r;
  fcr_state_t s;
  logic       aw_now;
  logic       w_now;
  logic       wr_fire;
  logic [5:0] widx;
  logic [7:0] wd;
  logic       wen;
  logic       rd_fire;
  logic       command_complete_flag;

  // ==========================================================================
  // write request as seen this cycle, held or arriving
  assign aw_now  = r.aw_have | (awvalid & r.awready);
  assign w_now   = r.w_have | (wvalid & r.wready);
  assign wr_fire = aw_now & w_now & ~r.bvalid;
  assign widx    = r.aw_have ? r.waddr : awaddr[7:2];
  assign wd      = r.w_have ? r.wdata : wdata[7:0];
  assign wen     = r.w_have ? r.wen : wstrb[0];
  assign rd_fire = arvalid & r.arready;
  assign command_complete_flag    = (r.cmd_st == FCR_CMD_IDLE);

  // ==========================================================================
  // read data mux, unmapped and reserved locations read zero
  function automatic logic [7:0] fcr_rd(input fcr_state_t q, input logic [5:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == `FCR_IDX_CLKDIV)
      v = {q.loaded, q.lock, q.div};
    else if (idx == `FCR_IDX_SEC)
      v = SEC_VALUE;
    else if (idx == `FCR_IDX_COMMAND_WORD_SELECT)
      v = {5'h00, q.command_word_select};
    else if (idx == `FCR_IDX_CNFG)
      v = {q.cnfg[3], 2'h0, q.cnfg[2], 2'h0, q.cnfg[1:0]};
    else if (idx == `FCR_IDX_ERCNFG)
      v = {6'h00, q.ercnfg};
    else if (idx == `FCR_IDX_STAT)
      v = {(q.cmd_st == FCR_CMD_IDLE), 7'h00};
    else if (idx == `FCR_IDX_PROGRAM_FLASH_PROTECTION)
      v = q.program_flash_protection;
    else if (idx == `FCR_IDX_DATA_FLASH_PROTECTION)
      v = q.data_flash_protection;
    else if (idx == `FCR_IDX_CCOBHI)
      v = q.ccob[q.command_word_select][15:8];
    else if (idx == `FCR_IDX_CCOBLO)
      v = q.ccob[q.command_word_select][7:0];
    return v;
  endfunction

  // ==========================================================================
  // next state
  always_comb
  begin
    s = r;
    // write address and data channels, taken in either order
    if (awvalid && r.awready)
    begin
      s.awready = 1'b0;
      s.aw_have = 1'b1;
      s.waddr   = awaddr[7:2];
    end
    if (wvalid && r.wready)
    begin
      s.wready = 1'b0;
      s.w_have = 1'b1;
      s.wdata  = wdata[7:0];
      s.wen    = wstrb[0];
    end
    // register write once both halves are present
    if (wr_fire)
    begin
      s.aw_have = 1'b0;
      s.w_have  = 1'b0;
      s.bvalid  = 1'b1;
      s.bresp   = (widx > `FCR_IDX_LAST) ? `FCR_RESP_SLVERR : `FCR_RESP_OKAY;
      if (wen)
      begin
        if (widx == `FCR_IDX_CLKDIV)
        begin
          s.loaded = 1'b1;
          if (!r.lock)
            s.div = wd[5:0];
          if (wd[`FCR_BIT_LOCK])
            s.lock = 1'b1;
        end
        else if (widx == `FCR_IDX_COMMAND_WORD_SELECT)
          s.command_word_select = wd[2:0];
        else if (widx == `FCR_IDX_CNFG)
          s.cnfg = {wd[`FCR_BIT_COMMAND_COMPLETE_IRQ_ENABLE], wd[`FCR_BIT_IGNSF], wd[`FCR_BIT_FDFD], wd[`FCR_BIT_FSFD]};
        else if (widx == `FCR_IDX_ERCNFG)
          s.ercnfg = wd[1:0];
        else if (widx == `FCR_IDX_STAT)
        begin
          if (wd[`FCR_BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag)
          begin
            s.cmd_st  = FCR_CMD_RUN;
            s.cmd_cnt = 8'h00;
          end
        end
        else if (widx == `FCR_IDX_PROGRAM_FLASH_PROTECTION)
          s.program_flash_protection = wd;
        else if (widx == `FCR_IDX_DATA_FLASH_PROTECTION)
          s.data_flash_protection = wd;
        else if (widx == `FCR_IDX_CCOBHI)
          s.ccob[r.command_word_select][15:8] = wd;
        else if (widx == `FCR_IDX_CCOBLO)
          s.ccob[r.command_word_select][7:0] = wd;
        // other indices change nothing
      end
    end
    // write response handshake reopens both channels
    if (r.bvalid && bready)
    begin
      s.bvalid  = 1'b0;
      s.awready = 1'b1;
      s.wready  = 1'b1;
    end
    // read channel, data registered one cycle after the address
    if (rd_fire)
    begin
      s.arready = 1'b0;
      s.rvalid  = 1'b1;
      s.rdata   = fcr_rd(r, araddr[7:2]);
      s.rresp   = (araddr[7:2] > `FCR_IDX_LAST) ? `FCR_RESP_SLVERR : `FCR_RESP_OKAY;
    end
    if (r.rvalid && rready)
    begin
      s.rvalid  = 1'b0;
      s.arready = 1'b1;
    end
    // divide bus clock by divide field plus one
    if (r.div_cnt >= r.div)
    begin
      s.div_cnt = 6'h00;
      s.tick    = 1'b1;
    end
    else
    begin
      s.div_cnt = r.div_cnt + 6'h01;
      s.tick    = 1'b0;
    end
    // command timer counts divided ticks
    case (r.cmd_st)
      // idle keeps the count cleared so every launch starts from zero
      FCR_CMD_IDLE:
        s.cmd_cnt = 8'h00;
      FCR_CMD_RUN:
        if (r.tick)
        begin
          if (r.cmd_cnt >= CMD_TICKS - 8'h01)
            s.cmd_st = FCR_CMD_IDLE;
          else
            s.cmd_cnt = r.cmd_cnt + 8'h01;
        end
      default:
        s.cmd_st = FCR_CMD_IDLE;
    endcase
    s.irq = (s.cmd_st == FCR_CMD_IDLE) & s.cnfg[3];
  end

  // ==========================================================================
  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r         <= '0;
      r.awready <= 1'b1;
      r.wready  <= 1'b1;
      r.arready <= 1'b1;
      r.cmd_st  <= FCR_CMD_IDLE;
    end
    else
      r <= s;
  end

  // ==========================================================================
  // outputs straight from the state register
  assign awready          = r.awready;
  assign wready           = r.wready;
  assign bvalid           = r.bvalid;
  assign bresp            = r.bresp;
  assign arready          = r.arready;
  assign rvalid           = r.rvalid;
  assign rresp            = r.rresp;
  assign rdata            = {24'h000000, r.rdata};
  assign cmd_complete_irq = r.irq;
  assign tick_1mhz        = r.tick;

  // ==========================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [6:0] gap;
  logic       div_chg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // no reference tick yet after reset, so the first spacing is not judged
      gap     <= 7'h00;
      div_chg <= 1'b1;
    end
    else if (r.tick)
    begin
      gap     <= 7'h00;
      div_chg <= 1'b0;
    end
    else
    begin
      gap     <= gap + 7'h01;
      div_chg <= div_chg | (s.div != r.div);
    end
  end

  sequence s_launch;
    wr_fire && wen && widx == `FCR_IDX_STAT && wd[`FCR_BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag;
  endsequence
  sequence s_clkdiv_wr;
    wr_fire && wen && widx == `FCR_IDX_CLKDIV;
  endsequence

  property p_map;
    wr_fire && widx <= `FCR_IDX_LAST |=> bvalid && bresp == `FCR_RESP_OKAY;
  endproperty
  a_map: assert property (p_map) else $error("mapped write not answered okay");

  property p_rd_div;
    rd_fire && araddr[7:2] == `FCR_IDX_CLKDIV |=> rvalid && rdata[7:0] == {$past(r.loaded), $past(r.lock), $past(r.div)};
  endproperty
  a_rd_div: assert property (p_rd_div) else $error("divider read mismatch");

  property p_lock_freeze;
    s_clkdiv_wr and r.lock |=> $stable(r.div);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze) else $error("locked divide field changed");

  property p_lock_sticky;
    r.lock |=> r.lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared without reset");

  property p_loaded_hold;
    !r.loaded && !(wr_fire && wen && widx == `FCR_IDX_CLKDIV) |=> !r.loaded;
  endproperty
  a_loaded_hold: assert property (p_loaded_hold) else $error("loaded flag set without write");

  property p_loaded_set;
    s_clkdiv_wr |=> r.loaded ##1 r.loaded;
  endproperty
  a_loaded_set: assert property (p_loaded_set) else $error("loaded flag not set by write");

  property p_tick_gap;
    r.tick && !div_chg && $past(r.tick, 1) == 1'b0 |-> gap == {1'b0, r.div};
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("divided tick spacing wrong");

  property p_unmapped;
    wr_fire && widx > `FCR_IDX_LAST |=> bresp == `FCR_RESP_SLVERR && $stable(r.div) && $stable(r.program_flash_protection);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write had an effect");

  property p_irq;
    s_launch |=> !cmd_complete_irq && !command_complete_flag;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not withdrawn on launch");

  property p_ccob;
    wr_fire && wen && widx == `FCR_IDX_CCOBHI |=> r.ccob[$past(r.command_word_select)][15:8] == $past(wd);
  endproperty
  a_ccob: assert property (p_ccob) else $error("command word not written at index");
endmodule
`default_nettype wire

// ==== test_flash_ctrl_regs_clock_divider.sv ====
// Purpose: self-checking bench of the flash register bank with clock divider
// Assumes: fcr_regs on AXI4-Lite, stand-in command shortened to two ticks
// Notes:   the bench drives every port itself; no partner model
`include "fcr_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module test_flash_ctrl_regs_clock_divider;
  // ==========================================================================
  // signals
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  rs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, tick;
  int          err_count = 0;
  int          cmp_count = 0;

  // ==========================================================================
  // design under test
  fcr_regs #(.CMD_TICKS(8'h02)) i_fcr_regs (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cmd_complete_irq(irq), .tick_1mhz(tick)
  );

  // clock of 10 ns
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==========================================================================
  // tasks
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic s);
    logic got;
    logic aw_ok;
    logic w_ok;
    got = 1'b0;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    wstrb   <= {3'h0, s};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!got)
    begin
      // sample the answer while it stands, act at the next rising edge
      @(negedge aclk);
      aw_ok = (awready === 1'b1);
      w_ok  = (wready === 1'b1);
      got   = (bvalid === 1'b1);
      if (got)
        rs = bresp;
      @(posedge aclk);
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
      if (got)
        bready <= 1'b0;
    end
  endtask

  // one read, result left in rd and rs
  task automatic rd_reg(input logic [5:0] idx);
    logic got;
    logic ar_ok;
    got = 1'b0;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!got)
    begin
      // sample the answer while it stands, act at the next rising edge
      @(negedge aclk);
      ar_ok = (arready === 1'b1);
      got   = (rvalid === 1'b1);
      if (got)
      begin
        rd = rdata;
        rs = rresp;
      end
      @(posedge aclk);
      if (ar_ok)
        arvalid <= 1'b0;
      if (got)
        rready <= 1'b0;
    end
  endtask

  // read and compare the whole word, upper bytes must be zero
  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp, input string what);
    rd_reg(idx);
    check(what, rd, {24'h000000, exp});
  endtask

  // cycles between two tick pulses
  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    // the pulse is looked at mid-cycle, where it stands settled
    @(negedge aclk);
    while (tick !== 1'b1) @(negedge aclk);
    do
    begin
      @(negedge aclk);
      n++;
    end while (tick !== 1'b1 && n < 100);
    @(posedge aclk);
    check("tick gap", 32'(n), 32'(exp));
  endtask

  // reset held for six cycles
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // verdict and end of run
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    $display("watchdog expired");
    summarize;
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h00000000; wstrb = 4'h0; aresetn = 1'b0;
    do_reset;
    // reset state and a write with its strobe off
    rchk(`FCR_IDX_CLKDIV, 8'h00, "divider after reset");
    rchk(`FCR_IDX_STAT, 8'h80, "status idle");
    wr(`FCR_IDX_CLKDIV, 8'h05, 1'b0);
    rchk(`FCR_IDX_CLKDIV, 8'h00, "divider strobe off");
    tick_gap(1);
    $display("test reset state done");
    // divide field, loaded flag, lock
    wr(`FCR_IDX_CLKDIV, 8'h05, 1'b1);
    rchk(`FCR_IDX_CLKDIV, 8'h85, "divider loaded");
    tick_gap(6);
    wr(`FCR_IDX_CLKDIV, 8'h42, 1'b1);
    rchk(`FCR_IDX_CLKDIV, 8'hC2, "divider lock set");
    wr(`FCR_IDX_CLKDIV, 8'h87, 1'b1);
    rchk(`FCR_IDX_CLKDIV, 8'hC2, "divider locked");
    tick_gap(3);
    do_reset;
    rchk(`FCR_IDX_CLKDIV, 8'h00, "divider second reset");
    wr(`FCR_IDX_CLKDIV, 8'h09, 1'b1);
    rchk(`FCR_IDX_CLKDIV, 8'h89, "divider open again");
    $display("test divider done");
    // map, reserved and unmapped places
    for (int i = 0; i <= 19; i++)
    begin
      rd_reg(6'(i));
      check("in range answer", 32'(rs), 32'(`FCR_RESP_OKAY));
    end
    wr(`FCR_IDX_RSV0, 8'hFF, 1'b1);
    rchk(`FCR_IDX_RSV0, 8'h00, "reserved write");
    wr(6'h0C, 8'hFF, 1'b1);
    rchk(6'h0C, 8'h00, "unused write");
    wr(6'h14, 8'hFF, 1'b1);
    check("unmapped write answer", 32'(rs), 32'(`FCR_RESP_SLVERR));
    rchk(6'h14, 8'h00, "unmapped read");
    check("unmapped read answer", 32'(rs), 32'(`FCR_RESP_SLVERR));
    $display("test map done");
    // command words through the index
    for (int i = 0; i < 2; i++)
    begin
      wr(`FCR_IDX_COMMAND_WORD_SELECT, 8'(i), 1'b1);
      wr(`FCR_IDX_CCOBHI, 8'(8'h12 + 8'(i)), 1'b1);
      wr(`FCR_IDX_CCOBLO, 8'(8'h34 + 8'(i)), 1'b1);
    end
    for (int i = 0; i < 2; i++)
    begin
      wr(`FCR_IDX_COMMAND_WORD_SELECT, 8'(i), 1'b1);
      rchk(`FCR_IDX_CCOBHI, 8'(8'h12 + 8'(i)), "command word high");
      rchk(`FCR_IDX_CCOBLO, 8'(8'h34 + 8'(i)), "command word low");
    end
    $display("test command words done");
    // interrupt follows flag and enable, command timed by the divided clock
    wr(`FCR_IDX_CNFG, 8'h80, 1'b1);
    check("irq enabled idle", 32'(irq), 32'h1);
    wr(`FCR_IDX_STAT, 8'h80, 1'b1);
    check("irq while busy", 32'(irq), 32'h0);
    rchk(`FCR_IDX_STAT, 8'h00, "status busy");
    // poll until idle, no divider write meanwhile
    for (int i = 0; i < 40 && rd[7:0] !== 8'h80; i++) rd_reg(`FCR_IDX_STAT);
    check("status done", rd, 32'h00000080);
    check("irq on completion", 32'(irq), 32'h1);
    wr(`FCR_IDX_CNFG, 8'h00, 1'b1);
    check("irq disabled", 32'(irq), 32'h0);
    $display("test interrupt done");
    summarize;
  end
endmodule
`default_nettype wire
